/* core/gpio_exp_pkg.sv */
// Shared constants and types for the I2C GPIO expander
package gpio_exp_pkg;
    localparam int NLINES = 16;
    localparam int CLK_PS = 5000;
    localparam int GLITCH_NS = 50;
    localparam int GLITCH_CYC = (GLITCH_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SCL_MAX_KHZ = 400;
    localparam int SCL_HALF_CYC = (1000000000 / (2 * SCL_MAX_KHZ)) / CLK_PS;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] ADDR_HI = 2'h1;
    // Register indices; REG_IN to REG_FALL shared by I2C command and APB word address, REG_EVT and REG_EMASK APB only
    localparam logic [3:0] REG_IN    = 4'h0;
    localparam logic [3:0] REG_OUT   = 4'h1;
    localparam logic [3:0] REG_INV   = 4'h2;
    localparam logic [3:0] REG_DIR   = 4'h3;
    localparam logic [3:0] REG_PULL  = 4'h4;
    localparam logic [3:0] REG_IEN   = 4'h5;
    localparam logic [3:0] REG_HIZ   = 4'h6;
    localparam logic [3:0] REG_ISTAT = 4'h7;
    localparam logic [3:0] REG_RISE  = 4'h8;
    localparam logic [3:0] REG_FALL  = 4'h9;
    localparam logic [3:0] REG_EVT   = 4'hA;
    localparam logic [3:0] REG_EMASK = 4'hB;
    localparam int EVT_WR = 0;
    localparam int EVT_RD = 1;
    localparam int EVT_GPIO = 2;
    // Reset values
    localparam logic [15:0] DIR_RST = 16'hFFFF;
    localparam logic [15:0] OUT_RST = 16'hFFFF;
    localparam logic [15:0] PULL_RST_STD = 16'h0000;
    localparam logic [15:0] PULL_RST_PUP = 16'hFFFF;
    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0000,
        ST_ADDR     = 4'b0001,
        ST_ACK_ADDR = 4'b0010,
        ST_CMD      = 4'b0011,
        ST_ACK_CMD  = 4'b0100,
        ST_WDATA    = 4'b0101,
        ST_ACK_W    = 4'b0110,
        ST_RDATA    = 4'b0111,
        ST_RACK     = 4'b1000
    } i2c_st_t;
endpackage

/* core/glitch_filter.sv */
// Spike filter for one serial bus line
`timescale 1ns/10ps
`default_nettype none
module glitch_filter
    import gpio_exp_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic raw,
    output var  logic clean
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       out;
    } filt_t;

    filt_t s_ff;
    filt_t nxt_s;

    // (RULE10) Stable-count filter
    always_comb
    begin
        nxt_s = s_ff;
        if (raw == s_ff.out)
        begin
            nxt_s.cnt = 4'h0;
        end
        else if (s_ff.cnt == 4'(GLITCH_CYC - 1))
        begin
            nxt_s.cnt = 4'h0;
            nxt_s.out = raw;
        end
        else
        begin
            nxt_s.cnt = s_ff.cnt + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff.cnt <= 4'h0;
            s_ff.out <= 1'b1;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign clean = s_ff.out;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    glitch_hold_a: assert property (clean != $past(clean) |-> $past(raw) == clean && $past(s_ff.cnt) == 4'(GLITCH_CYC - 1)) else $error("filter output changed early"); // (RULE10)
endmodule
`default_nettype wire

/* core/line_event.sv */
// Edge interrupt cell for one expander line
`timescale 1ns/10ps
`default_nettype none
module line_event (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic lvl,
    input  wire logic arm,
    input  wire logic rise_sel,
    input  wire logic fall_sel,
    input  wire logic rd_clr,
    output var  logic pend
);
    typedef struct packed {
        logic prev;
        logic base;
        logic pend;
    } cell_t;

    cell_t s_ff;
    cell_t nxt_s;
    logic  edge_hit;
    logic  back;
    logic  set_ev;
    logic  clr_ev;

    always_comb
    begin
        nxt_s = s_ff;
        // (RULE5) Selected edge type
        edge_hit = arm & ((~s_ff.prev & lvl & rise_sel) | (s_ff.prev & ~lvl & fall_sel));
        // (RULE6) Return to prior level
        back = s_ff.pend & (lvl == s_ff.base);
        set_ev = edge_hit & ~back;
        clr_ev = rd_clr | back | ~arm;
        // New event beats a read clear in the same cycle
        nxt_s.pend = set_ev | (s_ff.pend & ~clr_ev);
        if (set_ev && !s_ff.pend)
        begin
            nxt_s.base = s_ff.prev;
        end
        nxt_s.prev = lvl;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign pend = s_ff.pend;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    edge_set_a: assert property (set_ev |=> pend) else $error("edge did not set pending"); // (RULE5)
    read_clr_a: assert property (s_ff.pend && rd_clr && !set_ev |=> !pend) else $error("read did not clear"); // (RULE6)
    level_back_a: assert property (pend && lvl == s_ff.base |=> !pend) else $error("return did not clear"); // (RULE6)
endmodule
`default_nettype wire

/* core/gpio_expander.sv */
// I2C controlled 16-line GPIO expander with APB register view
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// (RULE1) Per-line pull-up, host enabled
// (RULE2) Pull-up variant resets with pull-ups on
// (RULE3) Output lines: high, low or hi-Z
// (RULE4) Input level inverted when selected
// (RULE5) Interrupt on rising, falling or both
// (RULE6) Clear on level return or input read
// (RULE7) Interrupt pin pulled low, never high
// (RULE8) Slave address from select pins, 32 choices
// (RULE9) Works with serial clock to 400kHz
// (RULE10) Glitch filter on SDA and SCL
// (RULE11) SDA driven low only, open drain
// (RULE12) All lines inputs after reset
// (RULE13) Standard variant: pull-ups off after reset
// (RULE14) Command byte selects register over I2C
module gpio_expander
    import gpio_exp_pkg::*;
#(
    parameter bit PULLUP_DEFAULT = 1'b0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output var  logic        sda_out,
    output var  logic        sda_oe,
    input  wire logic [1:0]  slave_addr_select_0,
    input  wire logic [1:0]  slave_addr_select_1,
    input  wire logic [1:0]  slave_addr_select_2,
    input  wire logic [15:0] expander_io_lines_in,
    output var  logic [15:0] expander_io_lines_out,
    output var  logic [15:0] expander_io_lines_oe,
    output var  logic [15:0] pull_en,
    output var  logic        irq_n_out,
    output var  logic        irq_n_oe,
    output var  logic        evt_irq
);
    typedef struct packed {
        i2c_st_t     st;
        logic [3:0]  bits;
        logic [7:0]  sh;
        logic        rw;
        logic [4:0]  ptr;
        logic        mack;
        logic [6:0]  my_addr;
        logic        scl_q;
        logic        sda_q;
        logic [15:0] outr;
        logic [15:0] inv;
        logic [15:0] dir;
        logic [15:0] pull;
        logic [15:0] ien;
        logic [15:0] hiz;
        logic [15:0] rise;
        logic [15:0] fall;
        logic [15:0] io_out;
        logic [15:0] io_oe;
        logic [15:0] pull_o;
        logic        sda_oe;
        logic        irq_oe;
        logic        od_low;
        logic [2:0]  evt;
        logic [2:0]  emask;
        logic        evt_irq;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } state_t;

    state_t       s_ff;
    state_t       nxt_s;
    logic         scl_f;
    logic         sda_f;
    logic [15:0]  pend;
    logic [15:0]  in_lvl;
    logic         rd_in_clr;
    logic         rd_load;
    logic         i2c_we;
    logic         evt_clr;
    logic         start;
    logic         stop;
    logic         scl_rise;
    logic         scl_fall;
    logic [4:0]   rd_ptr;
    logic [15:0]  rd_word;
    logic [7:0]   rd_byte;
    logic [3:0]   apb_idx;
    logic         mapped;
    logic         access;
    logic         done;
    logic [31:0]  apb_rd;

    // ------------------------------------------------------------
    // Bus line filters
    // ------------------------------------------------------------
    // (RULE9) Filter delay far below a 400 kHz half period
    glitch_filter u_scl_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     (scl_in),
        .clean   (scl_f)
    );

    glitch_filter u_sda_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     (sda_in),
        .clean   (sda_f)
    );

    // ------------------------------------------------------------
    // Per-line interrupt cells
    // ------------------------------------------------------------
    for (genvar i = 0; i < NLINES; i++)
    begin : g_line
        line_event u_ev (
            .pclk     (pclk),
            .presetn  (presetn),
            .lvl      (expander_io_lines_in[i]),
            .arm      (s_ff.ien[i] & s_ff.dir[i]),
            .rise_sel (s_ff.rise[i]),
            .fall_sel (s_ff.fall[i]),
            .rd_clr   (rd_in_clr),
            .pend     (pend[i])
        );
    end

    // ------------------------------------------------------------
    // Register access helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] mrg(input logic [15:0] o, input logic [15:0] v,
                                        input logic [15:0] m);
        return (o & ~m) | (v & m);
    endfunction

    function automatic logic [15:0] reg_val(input state_t r, input logic [3:0] i,
                                            input logic [15:0] lvl, input logic [15:0] p);
        case (i)
            REG_IN:    return lvl;
            REG_OUT:   return r.outr;
            REG_INV:   return r.inv;
            REG_DIR:   return r.dir;
            REG_PULL:  return r.pull;
            REG_IEN:   return r.ien;
            REG_HIZ:   return r.hiz;
            REG_ISTAT: return p;
            REG_RISE:  return r.rise;
            REG_FALL:  return r.fall;
            default:   return 16'h0000;
        endcase
    endfunction

    // Input and status registers ignore writes
    function automatic state_t reg_put(input state_t r, input logic [3:0] i,
                                       input logic [15:0] v, input logic [15:0] m);
        state_t q;
        q = r;
        case (i)
            REG_OUT:  q.outr = mrg(r.outr, v, m);
            REG_INV:  q.inv = mrg(r.inv, v, m);
            REG_DIR:  q.dir = mrg(r.dir, v, m);
            REG_PULL: q.pull = mrg(r.pull, v, m);
            REG_IEN:  q.ien = mrg(r.ien, v, m);
            REG_HIZ:  q.hiz = mrg(r.hiz, v, m);
            REG_RISE: q.rise = mrg(r.rise, v, m);
            REG_FALL: q.fall = mrg(r.fall, v, m);
            default:  q = r;
        endcase
        return q;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_s = s_ff;
        rd_in_clr = 1'b0;
        rd_load = 1'b0;
        i2c_we = 1'b0;
        evt_clr = 1'b0;
        // (RULE4) Polarity inversion
        in_lvl = expander_io_lines_in ^ s_ff.inv;
        start = s_ff.scl_q & scl_f & s_ff.sda_q & ~sda_f;
        stop = s_ff.scl_q & scl_f & ~s_ff.sda_q & sda_f;
        scl_rise = ~s_ff.scl_q & scl_f;
        scl_fall = s_ff.scl_q & ~scl_f;
        rd_ptr = (s_ff.st == ST_RACK) ? {s_ff.ptr[4:1], ~s_ff.ptr[0]} : s_ff.ptr;
        rd_word = reg_val(s_ff, rd_ptr[4:1], in_lvl, pend);
        rd_byte = rd_ptr[0] ? rd_word[15:8] : rd_word[7:0];
        nxt_s.scl_q = scl_f;
        nxt_s.sda_q = sda_f;

        if (start)
        begin
            nxt_s.st = ST_ADDR;
            nxt_s.bits = 4'h0;
            nxt_s.sda_oe = 1'b0;
            // (RULE8) Address caught at each start
            nxt_s.my_addr = {ADDR_HI, slave_addr_select_2[0],
                             slave_addr_select_1, slave_addr_select_0};
        end
        else if (stop)
        begin
            nxt_s.st = ST_IDLE;
            nxt_s.sda_oe = 1'b0;
        end
        else if (scl_rise)
        begin
            if (s_ff.st == ST_ADDR || s_ff.st == ST_CMD || s_ff.st == ST_WDATA)
            begin
                nxt_s.sh = {s_ff.sh[6:0], sda_f};
                nxt_s.bits = s_ff.bits + 4'h1;
            end
            else if (s_ff.st == ST_RDATA)
            begin
                nxt_s.bits = s_ff.bits + 4'h1;
            end
            else if (s_ff.st == ST_RACK)
            begin
                nxt_s.mack = ~sda_f;
            end
        end
        else if (scl_fall)
        begin
            // (RULE11) SDA only pulled low for ack and zeros
            case (s_ff.st)
                ST_ADDR:
                    if (s_ff.bits == BYTE_BITS)
                    begin
                        // (RULE8) Answer own address only
                        if (s_ff.sh[7:1] == s_ff.my_addr)
                        begin
                            nxt_s.rw = s_ff.sh[0];
                            nxt_s.st = ST_ACK_ADDR;
                            nxt_s.sda_oe = 1'b1;
                        end
                        else
                        begin
                            nxt_s.st = ST_IDLE;
                        end
                    end
                ST_ACK_ADDR:
                begin
                    nxt_s.bits = 4'h0;
                    if (s_ff.rw)
                    begin
                        nxt_s.st = ST_RDATA;
                        nxt_s.sh = rd_byte;
                        nxt_s.sda_oe = ~rd_byte[7];
                        rd_load = 1'b1;
                    end
                    else
                    begin
                        nxt_s.st = ST_CMD;
                        nxt_s.sda_oe = 1'b0;
                    end
                end
                ST_CMD:
                    if (s_ff.bits == BYTE_BITS)
                    begin
                        // (RULE14) Command byte sets pointer
                        nxt_s.ptr = s_ff.sh[4:0];
                        nxt_s.st = ST_ACK_CMD;
                        nxt_s.sda_oe = 1'b1;
                    end
                ST_ACK_CMD, ST_ACK_W:
                begin
                    nxt_s.st = ST_WDATA;
                    nxt_s.bits = 4'h0;
                    nxt_s.sda_oe = 1'b0;
                end
                ST_WDATA:
                    if (s_ff.bits == BYTE_BITS)
                    begin
                        i2c_we = 1'b1;
                        nxt_s.st = ST_ACK_W;
                        nxt_s.sda_oe = 1'b1;
                        nxt_s.ptr = {s_ff.ptr[4:1], ~s_ff.ptr[0]};
                    end
                ST_RDATA:
                    if (s_ff.bits == BYTE_BITS)
                    begin
                        nxt_s.sda_oe = 1'b0;
                        nxt_s.st = ST_RACK;
                    end
                    else
                    begin
                        nxt_s.sh = {s_ff.sh[6:0], 1'b0};
                        nxt_s.sda_oe = ~s_ff.sh[6];
                    end
                ST_RACK:
                    if (s_ff.mack)
                    begin
                        nxt_s.ptr = rd_ptr;
                        nxt_s.st = ST_RDATA;
                        nxt_s.bits = 4'h0;
                        nxt_s.sh = rd_byte;
                        nxt_s.sda_oe = ~rd_byte[7];
                        rd_load = 1'b1;
                    end
                    else
                    begin
                        nxt_s.st = ST_IDLE;
                    end
                default:
                    nxt_s.st = ST_IDLE;
            endcase
        end

        // (RULE6) Reading the input register clears
        if (rd_load && rd_ptr[4:1] == REG_IN)
        begin
            rd_in_clr = 1'b1;
        end
        // (RULE14) Byte write through the pointer
        if (i2c_we)
        begin
            nxt_s = reg_put(nxt_s, s_ff.ptr[4:1], {s_ff.sh, s_ff.sh},
                            s_ff.ptr[0] ? 16'hFF00 : 16'h00FF);
        end

        // APB slave: one wait state, APB wins a same-cycle clash
        apb_idx = paddr[5:2];
        mapped = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) && (apb_idx <= REG_EMASK);
        access = psel & penable;
        done = access & s_ff.pready;
        if (apb_idx == REG_EVT)
        begin
            apb_rd = {29'h0, s_ff.evt};
        end
        else if (apb_idx == REG_EMASK)
        begin
            apb_rd = {29'h0, s_ff.emask};
        end
        else
        begin
            apb_rd = {16'h0, reg_val(s_ff, apb_idx, in_lvl, pend)};
        end
        nxt_s.pready = access & ~s_ff.pready;
        nxt_s.pslverr = access & ~s_ff.pready & ~mapped;
        if (access && !s_ff.pready)
        begin
            nxt_s.prdata = (mapped && !pwrite) ? apb_rd : 32'h0;
        end
        if (done && mapped)
        begin
            if (pwrite)
            begin
                if (apb_idx == REG_EMASK)
                begin
                    nxt_s.emask = pwdata[2:0];
                end
                else
                begin
                    // (RULE1) Pull-up enables written here too
                    nxt_s = reg_put(nxt_s, apb_idx, pwdata[15:0], 16'hFFFF);
                end
            end
            else if (apb_idx == REG_EVT)
            begin
                evt_clr = 1'b1;
            end
            else if (apb_idx == REG_IN)
            begin
                rd_in_clr = 1'b1;
            end
        end

        // Sticky events, set beats read clear
        nxt_s.evt = (s_ff.evt & (evt_clr ? 3'h0 : 3'h7)) | {|pend, rd_load, i2c_we};
        nxt_s.evt_irq = |(nxt_s.evt & nxt_s.emask);

        // (RULE3) Drive only non-input, non-hiZ lines
        nxt_s.io_out = nxt_s.outr;
        nxt_s.io_oe = ~nxt_s.dir & ~nxt_s.hiz;
        nxt_s.pull_o = nxt_s.pull;
        // (RULE7) Pull request pin low while pending
        nxt_s.irq_oe = |pend;
        nxt_s.od_low = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff <= '0;
            s_ff.scl_q <= 1'b1;
            s_ff.sda_q <= 1'b1;
            // (RULE12) All lines input
            s_ff.dir <= DIR_RST;
            s_ff.outr <= OUT_RST;
            s_ff.io_out <= OUT_RST;
            // (RULE2) (RULE13) Pull-up reset by variant
            s_ff.pull <= PULLUP_DEFAULT ? PULL_RST_PUP : PULL_RST_STD;
            s_ff.pull_o <= PULLUP_DEFAULT ? PULL_RST_PUP : PULL_RST_STD;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign prdata = s_ff.prdata;
    assign pready = s_ff.pready;
    assign pslverr = s_ff.pslverr;
    assign sda_out = s_ff.od_low;
    assign sda_oe = s_ff.sda_oe;
    assign expander_io_lines_out = s_ff.io_out;
    assign expander_io_lines_oe = s_ff.io_oe;
    assign pull_en = s_ff.pull_o;
    assign irq_n_out = s_ff.od_low;
    assign irq_n_oe = s_ff.irq_oe;
    assign evt_irq = s_ff.evt_irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sda_only_low_a: assert property (sda_out == 1'b0 and (sda_oe |-> s_ff.st inside {ST_ACK_ADDR, ST_ACK_CMD, ST_ACK_W, ST_RDATA})) else $error("sda drive outside ack or data"); // (RULE11)
    irq_pin_a: assert property (irq_n_out == 1'b0 && irq_n_oe == $past(|pend)) else $error("irq pin mismatch"); // (RULE7)
    out_hiz_a: assert property (expander_io_lines_oe == (~s_ff.dir & ~s_ff.hiz)) else $error("output enable mismatch"); // (RULE3)
    reset_dir_a: assert property (@(posedge pclk) $rose(presetn) |-> expander_io_lines_oe == 16'h0000) else $error("lines not inputs after reset"); // (RULE12)
    reset_pull_a: assert property (@(posedge pclk) $rose(presetn) |-> pull_en == (PULLUP_DEFAULT ? PULL_RST_PUP : PULL_RST_STD)) else $error("pull-up reset wrong"); // (RULE2)
    pull_write_a: assert property (done && pwrite && mapped && apb_idx == REG_PULL |=> pull_en == $past(pwdata[15:0])) else $error("pull-up write lost"); // (RULE1)
    inv_read_a: assert property (access && !s_ff.pready && !pwrite && mapped && apb_idx == REG_IN |=> prdata[15:0] == $past(expander_io_lines_in ^ s_ff.inv)) else $error("inverted input wrong"); // (RULE4)
    addr_miss_a: assert property (scl_fall && !start && !stop && s_ff.st == ST_ADDR && s_ff.bits == BYTE_BITS && s_ff.sh[7:1] != s_ff.my_addr |=> s_ff.st == ST_IDLE && !sda_oe) else $error("acked foreign address"); // (RULE8)
    cmd_ptr_a: assert property (scl_fall && !start && !stop && s_ff.st == ST_CMD && s_ff.bits == BYTE_BITS |=> s_ff.ptr == $past(s_ff.sh[4:0]) && s_ff.st == ST_ACK_CMD) else $error("command byte not taken"); // (RULE14)
    apb_wait_a: assert property (access && !s_ff.pready |=> pready ##1 !pready) else $error("apb answer timing"); // APB wait-state timing, decided locally
    i2c_write_c: cover property (i2c_we);
    i2c_read_in_c: cover property (rd_load && rd_in_clr);
    gpio_pend_c: cover property ($rose(irq_n_oe));
    evt_clear_c: cover property (evt_clr && |s_ff.evt);
endmodule
`default_nettype wire

/* dv/i2c_host_model.sv */
// Behavioural I2C host for the expander serial pins
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model
    import gpio_exp_pkg::*;
(
    input  wire logic pclk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_rel
);
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic hp();
        repeat (SCL_HALF_CYC) @(posedge pclk);
    endtask
    // Data moves well after SCL falls, for hold
    task automatic bit_out(input logic b);
        scl <= 1'b0;
        repeat (20) @(posedge pclk);
        sda_rel <= b;
        hp();
        scl <= 1'b1;
        hp();
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] c,
                      input logic [7:0] d, output logic ack);
        logic [26:0] s;
        s = {a, 1'b0, 1'b1, c, 1'b1, d, 1'b1};
        ack = 1'b0;
        sda_rel <= 1'b0;
        hp();
        for (int i = 26; i >= 0; i--)
        begin
            bit_out(s[i]);
            if (i == 18)
                ack = !sda;
        end
        bit_out(1'b0);
        sda_rel <= 1'b1;
        hp();
    endtask
endmodule
`default_nettype wire

/* dv/gpio_expander_tb.sv */
// Self-checking bench for the I2C GPIO expander
`timescale 1ns/10ps
`default_nettype none
module gpio_expander_tb
    import gpio_exp_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, scl, sda_rel, sda_out, sda_oe, ack, er;
    logic        irq_n_out, irq_n_oe, evt_irq;
    logic [1:0]  sel0 = 2'h0, sel1 = 2'h0, sel2 = 2'h0;
    logic [15:0] pins = 16'h0000, io_out, io_oe, pull_en, pull_p, r, v;
    int          fail_count = 0, check_count = 0, seed = 15432, m;
    wire logic   sda = sda_rel & !(sda_oe & !sda_out);
    always #2.5 pclk = !pclk;
    gpio_expander dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .slave_addr_select_0(sel0),
        .slave_addr_select_1(sel1), .slave_addr_select_2(sel2),
        .expander_io_lines_in(pins), .expander_io_lines_out(io_out),
        .expander_io_lines_oe(io_oe), .pull_en(pull_en), .irq_n_out(irq_n_out),
        .irq_n_oe(irq_n_oe), .evt_irq(evt_irq));
    i2c_host_model host (.pclk(pclk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
    // Pull-up variant, only its reset state is checked
    gpio_expander #(.PULLUP_DEFAULT(1'b1)) dut_p (.pclk(pclk), .presetn(presetn),
        .paddr(8'h00), .psel(1'b0), .penable(1'b0), .pwrite(1'b0), .pwdata(32'h0),
        .prdata(), .pready(), .pslverr(), .scl_in(1'b1), .sda_in(1'b1), .sda_out(),
        .sda_oe(), .slave_addr_select_0(2'h0), .slave_addr_select_1(2'h0),
        .slave_addr_select_2(2'h0), .expander_io_lines_in(16'h0000),
        .expander_io_lines_out(), .expander_io_lines_oe(), .pull_en(pull_p),
        .irq_n_out(), .irq_n_oe(), .evt_irq());
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [3:0] i, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic stop_test();
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #400us;
        fail_count++;
        stop_test();
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("oe", io_oe, 16'h0000);
        chk("pull", pull_en, 16'h0000);
        chk("pullp", pull_p, 16'hFFFF);
        apb(1'b0, REG_DIR, 32'h0);
        chk("dir", rd, 32'h0000FFFF);
        r = 16'($random(seed));
        v = 16'($random(seed));
        apb(1'b1, REG_OUT, {16'h0000, r});
        apb(1'b1, REG_HIZ, {16'h0000, v});
        apb(1'b1, REG_DIR, 32'h0000F000);
        chk("out", io_out, r);
        chk("drv", io_oe, ~v & 16'h0FFF);
        apb(1'b1, REG_PULL, {16'h0000, v});
        chk("pullw", pull_en, v);
        apb(1'b1, REG_INV, {16'h0000, v});
        pins <= r;
        repeat (4) @(posedge pclk);
        apb(1'b0, REG_IN, 32'h0);
        chk("in", rd, {16'h0000, r ^ v});
        apb(1'b1, REG_DIR, 32'h0000FFFF);
        apb(1'b1, REG_IEN, 32'h00000008);
        // Modes 1 rise, 2 fall, 3 both on line 3
        for (m = 1; m < 4; m++)
        begin
            apb(1'b1, REG_RISE, {28'h0, m[0], 3'h0});
            apb(1'b1, REG_FALL, {28'h0, m[1], 3'h0});
            pins <= 16'h0000;
            repeat (6) @(posedge pclk);
            apb(1'b0, REG_IN, 32'h0);
            pins <= 16'h0008;
            repeat (6) @(posedge pclk);
            chk("rise", irq_n_oe, m[0]);
            pins <= 16'h0000;
            repeat (6) @(posedge pclk);
            chk("fall", irq_n_oe, m == 2);
            apb(1'b0, REG_ISTAT, 32'h0);
            chk("pend", rd, {28'h0, m == 2, 3'h0});
            apb(1'b0, REG_IN, 32'h0);
            // Pin enable trails the pending bit by one cycle
            @(posedge pclk);
            chk("clr", irq_n_oe, 1'b0);
            chk("pin", irq_n_out, 1'b0);
        end
        apb(1'b0, 4'hC, 32'h0);
        chk("err", er, 1'b1);
        chk("rdz", rd, 32'h0);
        apb(1'b0, REG_EVT, 32'h0);
        apb(1'b1, REG_EMASK, 32'h00000001);
        r = 16'($random(seed));
        {sel2, sel1, sel0} <= r[5:0];
        @(posedge pclk);
        host.wr({2'b01, r[4:0]}, 8'h08, 8'hA5, ack);
        chk("ack", ack, 1'b1);
        chk("pull", pull_en, {v[15:8], 8'hA5});
        chk("evt", evt_irq, 1'b1);
        apb(1'b0, REG_EVT, 32'h0);
        chk("evts", rd, 32'h1);
        chk("evtc", evt_irq, 1'b0);
        host.wr({2'b01, ~r[4:0]}, 8'h09, 8'h5A, ack);
        chk("nack", ack, 1'b0);
        chk("keep", pull_en, {v[15:8], 8'hA5});
        stop_test();
    end
endmodule
`default_nettype wire
